// File: core/acc_top.v
// Converter control: registers, source/reference routing, start and conversion sequencing
`timescale 1ns/100ps
`default_nettype none
`include "acc_regs.vh"

module acc_top (
   // Clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   // Converter core
   input  wire [11:0] conv_result,
   output reg         adc_power_on,
   output reg         conv_clk_tick,
   output reg         conv_sampling,
   output reg         conv_converting,
   output reg         conv_done,
   // Input source routing
   output reg         ext_path_sel,
   output reg  [3:0]  ext_channel_sel,
   output reg         sense_amp0_out_route,
   output reg         sense_amp1_out_route,
   output reg         ground_route,
   output reg         divided_route,
   output reg         amp_out_route,
   // Divided voltage source
   output reg         vdiv_supply_route,
   output reg         vdiv_battery_route,
   // Reference routing
   output reg         ref_pin_route,
   output reg         ref_supply_route,
   output reg         ref_amp_route,
   // Gain amplifier and temperature sensor
   output reg         gain_amp_enable,
   output reg  [1:0]  gain_level_sel,
   output reg         sensor_ref_indication,
   output reg         temp_pair_option,
   output reg         temp_sensor_on,
   // Interrupt
   output wire        irq
);

   // Software registers
   reg  [7:0]  ctrl_reg;
   reg  [7:0]  src_reg;
   reg  [7:0]  ana_reg;
   reg  [11:0] result_reg;
   reg         busy_reg;
   reg         start_armed_reg;
   reg  [4:0]  clk_cnt_reg;

   // Decoded fields
   wire [2:0]  input_source_sel;
   wire [1:0]  reference_sel;
   wire [2:0]  conv_clock_div_sel;
   wire [1:0]  voltage_input_sel;
   wire        result_justify_sel;
   wire        adcen;

   // Strobes
   wire        wr_ctrl;
   wire        wr_src;
   wire        wr_ana;
   wire        wr_stat;
   wire        wr_mask;
   wire        start_fall;
   wire        launch;
   wire        tick;
   wire        finish;
   wire        stat_q;
   wire        mask_q;

   // Read mux and routing decode
   reg  [7:0]  rd_next;
   reg  [5:0]  src_route_next;
   reg  [1:0]  vdiv_route_next;
   reg  [2:0]  ref_route_next;

   assign input_source_sel   = src_reg[`ACC_SRC_IN_HI:`ACC_SRC_IN_LO];
   assign reference_sel      = src_reg[`ACC_SRC_REF_HI:`ACC_SRC_REF_LO];
   assign conv_clock_div_sel = src_reg[`ACC_SRC_CK_HI:`ACC_SRC_CK_LO];
   assign voltage_input_sel  = ana_reg[`ACC_ANA_VIN_HI:`ACC_ANA_VIN_LO];
   assign result_justify_sel = ctrl_reg[`ACC_CTRL_JUSTIFY];
   assign adcen              = ctrl_reg[`ACC_CTRL_ENABLE];

   assign wr_ctrl = reg_wr && (reg_addr == `ACC_OFS_CTRL);
   assign wr_src  = reg_wr && (reg_addr == `ACC_OFS_SRC);
   assign wr_ana  = reg_wr && (reg_addr == `ACC_OFS_ANA);
   assign wr_stat = reg_wr && (reg_addr == `ACC_OFS_IRQ_STAT);
   assign wr_mask = reg_wr && (reg_addr == `ACC_OFS_IRQ_MASK);

   // Start launches on the write that brings an armed start bit back to zero
   assign start_fall = wr_ctrl && start_armed_reg && !reg_wdata[`ACC_CTRL_START];
   // Ignored while busy or while the converter is powered down
   assign launch     = start_fall && !busy_reg && adcen;
   assign finish     = busy_reg && tick && (clk_cnt_reg == `ACC_TOTAL_CLKS - 5'd1);

   // Source decode: one route per internal code, external path for 000, 110 and 111
   always @* begin
      src_route_next = 6'h00;
      case (input_source_sel)
         3'h1:    src_route_next = 6'h01;
         3'h2:    src_route_next = 6'h02;
         3'h3:    src_route_next = 6'h04;
         3'h4:    src_route_next = 6'h08;
         3'h5:    src_route_next = 6'h10;
         default: src_route_next = 6'h20;
      endcase
   end

   // Divided source decode; code 11 is not a legal setting and routes nothing
   always @* begin
      vdiv_route_next = 2'h0;
      case (voltage_input_sel)
         2'h1:    vdiv_route_next = 2'h1;
         2'h2:    vdiv_route_next = 2'h2;
         default: vdiv_route_next = 2'h0;
      endcase
   end

   // Reference decode; both supply codes share one route
   always @* begin
      ref_route_next = 3'h0;
      case (reference_sel)
         2'h0:    ref_route_next = 3'h1;
         2'h2:    ref_route_next = 3'h4;
         default: ref_route_next = 3'h2;
      endcase
   end

   // Configuration registers; reserved bit is stored as written and steers nothing
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `ACC_RST_CTRL;
         src_reg  <= `ACC_RST_SRC;
         ana_reg  <= `ACC_RST_ANA;
      end else begin
         if (wr_ctrl)
            ctrl_reg <= reg_wdata;
         if (wr_src)
            src_reg <= reg_wdata;
         if (wr_ana)
            ana_reg <= reg_wdata;
      end
   end

   // Start arming: remembers a zero-to-one write of the start bit
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         start_armed_reg <= 1'b0;
      end else if (wr_ctrl) begin
         start_armed_reg <= reg_wdata[`ACC_CTRL_START] &&
                            (start_armed_reg || !ctrl_reg[`ACC_CTRL_START]);
      end
   end

   // Converter clock enable, running only during a conversion
   acc_clkdiv u_clkdiv (
      .clk     (clk),
      .arst_n  (arst_n),
      .run     (busy_reg),
      .div_sel (conv_clock_div_sel),
      .tick    (tick)
   );

   // Conversion sequencer: busy from launch until the sixteenth converter clock
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_reg    <= 1'b0;
         clk_cnt_reg <= 5'd0;
         result_reg  <= 12'h000;
      end else if (launch) begin
         busy_reg    <= 1'b1;
         clk_cnt_reg <= 5'd0;
      end else if (finish) begin
         busy_reg    <= 1'b0;
         clk_cnt_reg <= 5'd0;
         result_reg  <= conv_result;
      end else if (busy_reg && !adcen) begin
         // Powering down aborts the conversion without a completion event
         busy_reg    <= 1'b0;
         clk_cnt_reg <= 5'd0;
      end else if (busy_reg && tick) begin
         clk_cnt_reg <= clk_cnt_reg + 5'd1;
      end
   end

   // Core handshake outputs, registered
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         adc_power_on    <= 1'b0;
         conv_clk_tick   <= 1'b0;
         conv_sampling   <= 1'b0;
         conv_converting <= 1'b0;
         conv_done       <= 1'b0;
      end else begin
         adc_power_on    <= adcen;
         conv_clk_tick   <= tick && busy_reg;
         conv_sampling   <= busy_reg && (clk_cnt_reg < `ACC_SAMPLE_CLKS);
         conv_converting <= busy_reg && (clk_cnt_reg >= `ACC_SAMPLE_CLKS);
         conv_done       <= finish;
      end
   end

   // Input source, divided source and reference routing, registered
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_path_sel         <= 1'b0;
         ext_channel_sel      <= 4'h0;
         sense_amp0_out_route <= 1'b0;
         sense_amp1_out_route <= 1'b0;
         ground_route         <= 1'b0;
         divided_route        <= 1'b0;
         amp_out_route        <= 1'b0;
         vdiv_supply_route    <= 1'b0;
         vdiv_battery_route   <= 1'b0;
         ref_pin_route        <= 1'b0;
         ref_supply_route     <= 1'b0;
         ref_amp_route        <= 1'b0;
      end else begin
         ext_path_sel         <= src_route_next[5];
         // Channel field passed through; parking it is left to software
         ext_channel_sel      <= ctrl_reg[`ACC_CTRL_CH_HI:`ACC_CTRL_CH_LO];
         sense_amp0_out_route <= src_route_next[0];
         sense_amp1_out_route <= src_route_next[1];
         ground_route         <= src_route_next[2];
         divided_route        <= src_route_next[3];
         amp_out_route        <= src_route_next[4];
         // Divider feeds the converter only under source code 100
         vdiv_supply_route    <= src_route_next[3] && vdiv_route_next[0];
         vdiv_battery_route   <= src_route_next[3] && vdiv_route_next[1];
         ref_pin_route        <= ref_route_next[0];
         ref_supply_route     <= ref_route_next[1];
         ref_amp_route        <= ref_route_next[2];
      end
   end

   // Gain amplifier and temperature sensor controls, registered
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gain_amp_enable       <= 1'b0;
         gain_level_sel        <= 2'h0;
         sensor_ref_indication <= 1'b0;
         temp_pair_option      <= 1'b0;
         temp_sensor_on        <= 1'b0;
      end else begin
         gain_amp_enable       <= ana_reg[`ACC_ANA_AMP_EN];
         // Bandgap readiness for levels 01..11 is software's duty
         gain_level_sel        <= ana_reg[`ACC_ANA_GAIN_HI:`ACC_ANA_GAIN_LO];
         sensor_ref_indication <= (ana_reg[`ACC_ANA_GAIN_HI:`ACC_ANA_GAIN_LO] == 2'h0);
         temp_pair_option      <= ana_reg[`ACC_ANA_TPAIR];
         // Settling wait after power-up is timed by software
         temp_sensor_on        <= ana_reg[`ACC_ANA_TEMP_SENSOR_ON];
      end
   end

   // Completion interrupt
   acc_irq u_irq (
      .clk      (clk),
      .arst_n   (arst_n),
      .evt      (finish),
      .stat_wr  (wr_stat),
      .mask_wr  (wr_mask),
      .wbit     (reg_wdata[`ACC_IRQ_DONE]),
      .stat_reg (stat_q),
      .mask_reg (mask_q),
      .irq      (irq)
   );

   // Read mux; busy reads live, unmapped addresses read zero
   always @* begin
      rd_next = 8'h00;
      case (reg_addr)
         `ACC_OFS_CTRL: begin
            rd_next = ctrl_reg;
            rd_next[`ACC_CTRL_BUSY] = busy_reg;
         end
         `ACC_OFS_SRC:      rd_next = src_reg;
         `ACC_OFS_ANA:      rd_next = ana_reg;
         `ACC_OFS_RES_HI:   rd_next = result_justify_sel ? {4'h0, result_reg[11:8]}
                                                         : result_reg[11:4];
         `ACC_OFS_RES_LO:   rd_next = result_justify_sel ? result_reg[7:0]
                                                         : {result_reg[3:0], 4'h0};
         `ACC_OFS_IRQ_STAT: rd_next = {7'h00, stat_q};
         `ACC_OFS_IRQ_MASK: rd_next = {7'h00, mask_q};
         default:           rd_next = 8'h00;
      endcase
   end

   // Read data valid the cycle after the strobe only
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rd_next;
      else
         reg_rdata <= 8'h00;
   end

endmodule // acc_top

`default_nettype wire

// File: core/acc_regs.vh
// Register offsets, field positions, reset values and counts of the converter control block
//
// Behaviour
// - Source codes 000/110/111 take external path; 001..101 pick internal signals in order.
// - Source code 100 routes the divided voltage chosen by the voltage-input field.
// - Reference 00 external pin, 01 and 11 supply, 10 internal amplifier output.
// - Converter clock is system clock divided by two to the clock select value.
// - Analog config bit 7 enables the gain amplifier.
// - Gain 00 gives sensor voltage with indication; 01/10/11 give fixed levels without.
// - Voltage input 00 floating, 01 supply, 10 battery pin, 11 not permitted.
// - Analog config bit 1 picks the temperature pairing, 1.6V or 3.0V.
// - Bit 0 powers the temperature sensor; software waits settling before use.
// - Start bit driven 0 then 1 then 0 launches one conversion.
// - Busy flag set while conversion runs, cleared when it finishes.
// - Completion sets the request flag; interrupt raised only when enabled.
// - Conversion is 4 sampling plus 12 converting clocks, busy throughout.
// - Justify bit 0: high holds D[11:4]; 1: high holds D[11:8].
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

// Register offsets (byte addresses)
`define ACC_OFS_CTRL      8'h00
`define ACC_OFS_SRC       8'h04
`define ACC_OFS_ANA       8'h08
`define ACC_OFS_RES_HI    8'h0c
`define ACC_OFS_RES_LO    8'h10
`define ACC_OFS_IRQ_STAT  8'h14
`define ACC_OFS_IRQ_MASK  8'h18

// Reset values
`define ACC_RST_CTRL      8'h00
`define ACC_RST_SRC       8'h00
`define ACC_RST_ANA       8'h00

// Control register fields
`define ACC_CTRL_START    7
`define ACC_CTRL_BUSY     6
`define ACC_CTRL_ENABLE   5
`define ACC_CTRL_JUSTIFY  4
`define ACC_CTRL_CH_HI    3
`define ACC_CTRL_CH_LO    0

// Source/reference/clock register fields
`define ACC_SRC_IN_HI     7
`define ACC_SRC_IN_LO     5
`define ACC_SRC_REF_HI    4
`define ACC_SRC_REF_LO    3
`define ACC_SRC_CK_HI     2
`define ACC_SRC_CK_LO     0

// Analog config register fields
`define ACC_ANA_AMP_EN    7
`define ACC_ANA_GAIN_HI   6
`define ACC_ANA_GAIN_LO   5
`define ACC_ANA_RSVD      4
`define ACC_ANA_VIN_HI    3
`define ACC_ANA_VIN_LO    2
`define ACC_ANA_TPAIR     1
`define ACC_ANA_TEMP_SENSOR_ON      0

// Interrupt bit position
`define ACC_IRQ_DONE      0

// Conversion timing in converter clocks
`define ACC_SAMPLE_CLKS   5'd4
`define ACC_CONV_CLKS     5'd12
`define ACC_TOTAL_CLKS    5'd16

`endif

// File: core/acc_clkdiv.v
// Converter clock divider: one-cycle enable pulse at system clock over two to the select
`timescale 1ns/100ps
`default_nettype none

module acc_clkdiv (
   // Clock and reset
   input  wire       clk,
   input  wire       arst_n,
   // Control
   input  wire       run,
   input  wire [2:0] div_sel,
   // Enable pulse
   output reg        tick
);

   reg  [6:0] cnt_reg;
   wire [6:0] limit;

   // Terminal count is two to the select minus one
   assign limit = ~(7'h7f << div_sel);

   // Restarted by run so the first tick of a conversion is one full period away
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 7'h00;
         tick    <= 1'b0;
      end else if (!run) begin
         cnt_reg <= 7'h00;
         tick    <= 1'b0;
      end else if (cnt_reg == limit) begin
         cnt_reg <= 7'h00;
         tick    <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 7'h01;
         tick    <= 1'b0;
      end
   end

endmodule // acc_clkdiv

`default_nettype wire

// File: core/acc_irq.v
// Sticky completion status, mask and level interrupt output
`timescale 1ns/100ps
`default_nettype none

module acc_irq (
   // Clock and reset
   input  wire clk,
   input  wire arst_n,
   // Event and software access
   input  wire evt,
   input  wire stat_wr,
   input  wire mask_wr,
   input  wire wbit,
   // State
   output reg  stat_reg,
   output reg  mask_reg,
   output reg  irq
);

   wire stat_next;

   // Write one clears; a same-cycle event wins over the clear
   assign stat_next = evt | (stat_reg & ~(stat_wr & wbit));

   // Status, mask and registered interrupt level
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stat_reg <= 1'b0;
         mask_reg <= 1'b0;
         irq      <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         if (mask_wr)
            mask_reg <= wbit;
         irq <= stat_next & (mask_wr ? wbit : mask_reg);
      end
   end

endmodule // acc_irq

`default_nettype wire

// File: dv/acc_core_model.sv
// Behavioural stand-in for the analog converter core
`timescale 1ns/100ps
`default_nettype none

module acc_core_model (
   // Phase indications
   input  wire logic        conv_sampling,
   input  wire logic        conv_converting,
   // Level to convert
   input  wire logic [11:0] level,
   // Result bus
   output wire logic [11:0] conv_result
);
   // Inverse outside a conversion, so a stray capture shows up
   assign conv_result = (conv_sampling || conv_converting) ? level : ~level;
endmodule // acc_core_model
`default_nettype wire

// File: dv/acc_top_properties.sv
// Port checks of the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "acc_regs.vh"

module acc_top_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   // Conversion
   input wire logic       conv_sampling,
   input wire logic       conv_converting,
   input wire logic       conv_done,
   // Routing
   input wire logic       ext_path_sel,
   input wire logic       sense_amp0_out_route,
   input wire logic       sense_amp1_out_route,
   input wire logic       ground_route,
   input wire logic       divided_route,
   input wire logic       amp_out_route,
   input wire logic       vdiv_supply_route,
   input wire logic       vdiv_battery_route,
   input wire logic       ref_pin_route,
   input wire logic       ref_supply_route,
   input wire logic       ref_amp_route,
   // Gain and sensor
   input wire logic       gain_amp_enable,
   input wire logic [1:0] gain_level_sel,
   input wire logic       sensor_ref_indication,
   input wire logic       temp_pair_option,
   input wire logic       temp_sensor_on
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // Analog config write strobe
   wire ana_wr = reg_wr && (reg_addr == `ACC_OFS_ANA);

   // Routing exclusivity and sensor indication
   AST_SRC_ONE: assert property ($onehot0({ext_path_sel, sense_amp0_out_route,
      sense_amp1_out_route, ground_route, divided_route, amp_out_route}))
      else $error("source routes overlap");
   AST_VDIV: assert property ((vdiv_supply_route || vdiv_battery_route) |->
      divided_route && !(vdiv_supply_route && vdiv_battery_route))
      else $error("divided source routed wrongly");
   AST_REF_ONE: assert property ($onehot0({ref_pin_route, ref_supply_route, ref_amp_route}))
      else $error("reference routes overlap");
   AST_INDIC: assert property ((gain_level_sel != 2'h0) |-> !sensor_ref_indication)
      else $error("sensor indication with fixed gain");
   // Conversion phases
   AST_PHASE: assert property (!(conv_sampling && conv_converting))
      else $error("sampling and converting together");
   AST_ORDER: assert property ($rose(conv_converting) |-> $past(conv_sampling))
      else $error("converting without sampling first");
   AST_DONE: assert property (conv_done |-> conv_converting ##1 !conv_converting)
      else $error("completion outside the end of converting");
   AST_PULSE: assert property (conv_done |=> !conv_done)
      else $error("completion longer than one cycle");
   // Config outputs follow writes two edges later
   AST_AMP_EN: assert property (ana_wr |-> ##2 gain_amp_enable == $past(reg_wdata[7], 2))
      else $error("amplifier enable not updated");
   AST_PAIR: assert property (ana_wr |-> ##2 temp_pair_option == $past(reg_wdata[1], 2))
      else $error("pairing option not updated");
   AST_TEMP_SENSOR_ON: assert property (ana_wr |-> ##2 temp_sensor_on == $past(reg_wdata[0], 2))
      else $error("sensor power not updated");

   COV_DONE: cover property (conv_done);
   COV_BAT: cover property (vdiv_battery_route);
   COV_REFAMP: cover property (ref_amp_route);
endmodule // acc_top_properties

bind acc_top acc_top_properties chk_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .conv_sampling(conv_sampling),
   .conv_converting(conv_converting), .conv_done(conv_done), .ext_path_sel(ext_path_sel),
   .sense_amp0_out_route(sense_amp0_out_route), .sense_amp1_out_route(sense_amp1_out_route),
   .ground_route(ground_route), .divided_route(divided_route), .amp_out_route(amp_out_route),
   .vdiv_supply_route(vdiv_supply_route), .vdiv_battery_route(vdiv_battery_route),
   .ref_pin_route(ref_pin_route), .ref_supply_route(ref_supply_route),
   .ref_amp_route(ref_amp_route), .gain_amp_enable(gain_amp_enable),
   .gain_level_sel(gain_level_sel), .sensor_ref_indication(sensor_ref_indication),
   .temp_pair_option(temp_pair_option), .temp_sensor_on(temp_sensor_on));
`default_nettype wire

// File: dv/acc_top_bench.sv
// Self-checking bench of the converter control block
`timescale 1ns/100ps
`default_nettype none

module acc_top_bench;
   logic        clk = 1'b0;
   logic        arst_n;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd;
   logic [11:0] conv_result, level;
   logic        conv_clk_tick, conv_sampling, conv_converting, conv_done;
   logic        ext_path_sel, vs, vb, gae, sri, tpo, tso, irq, apo;
   logic [3:0]  ecs;
   wire  [4:0]  rt;
   wire  [2:0]  rf;
   logic [1:0]  gls;
   int          n_errors, checked, n_ticks, n_dones, cyc, last, gap;

   always #10 clk = ~clk;

   acc_core_model core_u (.conv_sampling(conv_sampling), .conv_converting(conv_converting),
      .level(level), .conv_result(conv_result));

   acc_top dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_result(conv_result),
      .adc_power_on(apo), .conv_clk_tick(conv_clk_tick), .conv_sampling(conv_sampling),
      .conv_converting(conv_converting), .conv_done(conv_done), .ext_path_sel(ext_path_sel),
      .ext_channel_sel(ecs), .sense_amp0_out_route(rt[0]), .sense_amp1_out_route(rt[1]),
      .ground_route(rt[2]), .divided_route(rt[3]), .amp_out_route(rt[4]),
      .vdiv_supply_route(vs), .vdiv_battery_route(vb), .ref_pin_route(rf[0]),
      .ref_supply_route(rf[1]), .ref_amp_route(rf[2]), .gain_amp_enable(gae),
      .gain_level_sel(gls), .sensor_ref_indication(sri), .temp_pair_option(tpo),
      .temp_sensor_on(tso), .irq(irq));

   // Tick spacing and completion counts, kept apart from the scenarios
   always @(posedge clk) begin
      cyc++;
      if (conv_clk_tick === 1'b1) begin
         n_ticks++;
         gap = cyc - last;
         last = cyc;
      end
      if (conv_done === 1'b1)
         n_dones++;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle strobes with a free cycle after, so no strobe is set twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      // Data stands only until the next edge, so look mid-cycle
      @(negedge clk);
      chk(reg_rdata, exp);
      @(posedge clk);
   endtask

   task automatic t_reset();
      rdc(8'h04, 8'h00);
      rdc(8'h08, 8'h00);
      chk({ext_path_sel, rf, sri}, 5'h13);
      // Start pulse with the converter powered down must not launch
      wr(8'h00, 8'hc0);
      wr(8'h00, 8'h40);
      rdc(8'h00, 8'h00);
      rdc(8'h20, 8'h00);
   endtask

   task automatic t_routes();
      // Channel parked at 1000 while internal sources are chosen
      wr(8'h00, 8'h28);
      @(posedge clk);
      chk({apo, ecs}, 5'h18);
      for (int c = 0; c < 8; c++) begin
         wr(8'h04, {c[2:0], c[1:0], 3'h0});
         @(posedge clk);
         chk({ext_path_sel, rt}, (c == 0 || c > 5) ? 6'h20 : 6'h01 << (c - 1));
         chk(rf, (c[1:0] == 2'h0) ? 3'h1 : (c[1:0] == 2'h2) ? 3'h4 : 3'h2);
      end
      wr(8'h04, 8'h80);
      for (int v = 0; v < 4; v++) begin
         wr(8'h08, {4'h0, v[1:0], 2'h0});
         @(posedge clk);
         chk({vb, vs}, (v == 1) ? 2'h1 : (v == 2) ? 2'h2 : 2'h0);
      end
   endtask

   // Reserved bit 4 always written as zero; bandgap taken as already on
   task automatic t_ana();
      for (int g = 0; g < 4; g++) begin
         wr(8'h08, {g[0], g[1:0], 3'h0, g[0], g[1]});
         @(posedge clk);
         chk({gae, gls, sri, tpo, tso}, {g[0], g[1:0], g == 0, g[0], g[1]});
         rdc(8'h08, {g[0], g[1:0], 3'h0, g[0], g[1]});
      end
   endtask

   task automatic t_conv(input logic [2:0] sel, input logic msk, input logic again);
      int t;
      int k0;
      int d0;
      level <= 12'hb5c ^ {9'h0, sel};
      wr(8'h04, {5'h00, sel});
      wr(8'h18, {7'h00, msk});
      wr(8'h00, 8'h20);
      wr(8'h00, 8'ha0);
      k0 = n_ticks;
      d0 = n_dones;
      wr(8'h00, 8'h20);
      rdc(8'h00, 8'h60);
      if (again) begin
         wr(8'h00, 8'ha0);
         wr(8'h00, 8'h20);
      end
      t = 0;
      while (conv_done !== 1'b1 && t < 3000) begin
         @(negedge clk);
         t++;
      end
      chk(conv_done, 1'b1);
      repeat (3) @(posedge clk);
      chk(n_ticks - k0, 16'd16);
      chk(n_dones - d0, 16'd1);
      chk(gap, 16'd1 << sel);
      chk(irq, msk);
      rdc(8'h14, 8'h01);
      wr(8'h18, 8'h01);
      @(posedge clk);
      chk(irq, 1'b1);
      wr(8'h14, 8'h01);
      @(posedge clk);
      chk(irq, 1'b0);
      if (!again) begin
         wr(8'h00, 8'h30);
         rdc(8'h0c, {4'h0, level[11:8]});
         rdc(8'h10, level[7:0]);
         wr(8'h00, 8'h20);
         rdc(8'h0c, level[11:4]);
         rdc(8'h10, {level[3:0], 4'h0});
      end
   endtask

   task automatic close_out();
      if (n_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog: slowest conversion is about 2100 cycles, whole run far below this
   initial begin
      #(20 * 30000);
      n_errors++;
      close_out();
   end

   initial begin
      arst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      level = 12'h000;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_routes();
      t_ana();
      t_conv(3'h0, 1'b1, 1'b0);
      t_conv(3'h7, 1'b0, 1'b0); // 2.56 us converter period
      t_conv(3'h2, 1'b1, 1'b1);
      close_out();
   end
endmodule // acc_top_bench
`default_nettype wire
